// *** periph_flags_pkg.sv ***
// Constants, register map and mode types of the peripheral flag block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package periph_flags_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADR_W-1:0] OFS_FLAGS = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_ENABLES = 8'h10;
    localparam logic [ADR_W-1:0] OFS_CONTROL = 8'h14;
    localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h1C;

    // ****************************************
    // Flag field positions
    // ****************************************
    localparam int BIT_ADC = 6;
    localparam int BIT_SERIAL = 3;
    localparam int BIT_CCP = 2;
    localparam int BIT_TMR2 = 1;
    localparam int BIT_TIMER1_COUNT = 0;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h4F;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTL_GROUP_EN = 0;
    localparam int CTL_GLOBAL_EN = 1;
    localparam int CTL_CCP_LO = 2;
    localparam int CTL_SERIAL_I2C = 4;
    localparam logic [7:0] CTL_IMPL_MASK = 8'h1F;

    // ****************************************
    // Reset values and timer 1 count limit
    // ****************************************
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ENABLES_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [15:0] TIMER1_COUNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {CCP_CAPTURE, CCP_COMPARE, CCP_PWM} ccp_mode_t;

endpackage

// *** periph_event_detect.sv ***
// Turns raw peripheral activity into one-cycle flag-set events.
// Assumes every input is synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module periph_event_detect
    import periph_flags_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [1:0] ccpMode,
    input wire logic serialI2c,
    input wire logic adcDone,
    input wire logic serialXferDone,
    input wire logic serialStartDone,
    input wire logic serialStopDone,
    input wire logic serialRestartDone,
    input wire logic serialAckDone,
    input wire logic serialIdle,
    input wire logic busStartSeen,
    input wire logic busStopSeen,
    input wire logic ccpCapture,
    input wire logic [15:0] ccpCompareValue,
    input wire logic timer1Tick,
    input wire logic [15:0] timer1_count,
    input wire logic [7:0] timer2Count,
    input wire logic [7:0] timer2_period_value,
    output logic [7:0] events
);
    import periph_flags_pkg::*;

    logic cmpEq;
    logic cmpEqPrev;
    logic t2Eq;
    logic t2EqPrev;
    logic i2cSeq;
    logic i2cBus;

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    assign cmpEq = (timer1_count == ccpCompareValue);
    assign t2Eq = (timer2Count == timer2_period_value);
    assign i2cSeq = serialStartDone | serialStopDone | serialRestartDone
        | serialAckDone;
    assign i2cBus = serialIdle & (busStartSeen | busStopSeen);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmpEqPrev <= 1'b0;
            t2EqPrev <= 1'b0;
        end else begin
            cmpEqPrev <= cmpEq;
            t2EqPrev <= t2Eq;
        end
    end

    always_comb begin
        events = 8'h00;
        events[BIT_ADC] = adcDone;
        events[BIT_SERIAL] = serialXferDone;
        if (serialI2c) begin
            events[BIT_SERIAL] = serialXferDone | i2cSeq | i2cBus;
        end
        unique case (ccp_mode_t'(ccpMode))
            CCP_CAPTURE: events[BIT_CCP] = ccpCapture;
            CCP_COMPARE: events[BIT_CCP] = rise(cmpEq, cmpEqPrev);
            CCP_PWM: events[BIT_CCP] = 1'b0;
            default: events[BIT_CCP] = 1'b0;
        endcase
        events[BIT_TMR2] = rise(t2Eq, t2EqPrev);
        events[BIT_TIMER1_COUNT] = timer1Tick & (timer1_count == TIMER1_COUNT_MAX);
    end

endmodule // periph_event_detect
`default_nettype wire

// *** peripheral_interrupt_flags.sv ***
// Peripheral interrupt flag register with enables and a Wishbone slave.
// Assumes a classic Wishbone master on ref_clk; peripheral inputs synchronous.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Converter-done flag, bit 6, sets when a conversion completes.
// - Serial flag, bit 3, sets when a transfer finishes, SPI or I2C.
// - In I2C, serial flag sets when an initiated start/stop/restart/ack ends.
// - In I2C, serial flag sets on bus start or stop while port idle.
// - Capture mode: capture/compare flag, bit 2, sets on each capture.
// - Compare mode: flag sets on timer 1 match; PWM mode never sets it.
// - Timer 2 flag, bit 1, sets when timer 2 equals its period.
// - Timer 1 flag, bit 0, sets on timer 1 overflow, held until cleared.
// - Bits 7, 5 and 4 read zero and ignore writes.
// - Flags set on events regardless of any enable bit.
// - Request reaches CPU only with source enable and group enable both set.
module peripheral_interrupt_flags (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [periph_flags_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [periph_flags_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [periph_flags_pkg::DAT_W-1:0] wb_dat_i,
    output logic [periph_flags_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic adcDone,
    input wire logic serialXferDone,
    input wire logic serialStartDone,
    input wire logic serialStopDone,
    input wire logic serialRestartDone,
    input wire logic serialAckDone,
    input wire logic serialIdle,
    input wire logic busStartSeen,
    input wire logic busStopSeen,
    input wire logic ccpCapture,
    input wire logic [15:0] ccpCompareValue,
    input wire logic timer1Tick,
    input wire logic [15:0] timer1_count,
    input wire logic [7:0] timer2Count,
    input wire logic [7:0] timer2_period_value,
    output logic [7:0] peripheral_event_flags_1,
    output logic peripheralIrq,
    output logic cpuIrq,
    output logic irq
);
    import periph_flags_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] flags;
    logic [7:0] peripheral_event_enables_1;
    logic [7:0] control;
    logic [7:0] irqStatus;
    logic [7:0] irqMask;
    logic [7:0] events;
    logic [7:0] readValue;
    logic [7:0] readSnap;
    logic request;
    logic commit;
    logic wrLane0;
    logic [7:0] pending;

    function automatic logic hit(input logic [ADR_W-1:0] a,
                                 input logic [ADR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // ****************************************
    // Event detection
    // ****************************************
    periph_event_detect u_detect (
        .ref_clk(ref_clk),
        .srst(srst),
        .ccpMode(control[CTL_CCP_LO+1:CTL_CCP_LO]),
        .serialI2c(control[CTL_SERIAL_I2C]),
        .adcDone(adcDone),
        .serialXferDone(serialXferDone),
        .serialStartDone(serialStartDone),
        .serialStopDone(serialStopDone),
        .serialRestartDone(serialRestartDone),
        .serialAckDone(serialAckDone),
        .serialIdle(serialIdle),
        .busStartSeen(busStartSeen),
        .busStopSeen(busStopSeen),
        .ccpCapture(ccpCapture),
        .ccpCompareValue(ccpCompareValue),
        .timer1Tick(timer1Tick),
        .timer1_count(timer1_count),
        .timer2Count(timer2Count),
        .timer2_period_value(timer2_period_value),
        .events(events)
    );

    // ****************************************
    // Bus slave
    // ****************************************
    assign request = wb_cyc_i & wb_stb_i;
    assign commit = request & wb_ack_o;
    assign wrLane0 = commit & wb_we_i & wb_sel_i[0];

    always_comb begin
        readValue = 8'h00;
        if (hit(wb_adr_i, OFS_FLAGS)) begin
            readValue = flags & FLAG_IMPL_MASK;
        end else if (hit(wb_adr_i, OFS_ENABLES)) begin
            readValue = peripheral_event_enables_1 & FLAG_IMPL_MASK;
        end else if (hit(wb_adr_i, OFS_CONTROL)) begin
            readValue = control;
        end else if (hit(wb_adr_i, OFS_IRQ_STATUS)) begin
            readValue = irqStatus;
        end else if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
            readValue = irqMask;
        end
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            readSnap <= 8'h00;
        end else begin
            wb_ack_o <= request & ~wb_ack_o;
            if (request & ~wb_ack_o) begin
                wb_dat_o <= {24'h000000, readValue};
                readSnap <= readValue;
            end
        end
    end

    // ****************************************
    // Flag register
    // ****************************************
    // Set wins over a same-cycle software clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags <= FLAGS_RST;
        end else if (wrLane0 && hit(wb_adr_i, OFS_FLAGS)) begin
            flags <= (wb_dat_i[7:0] & FLAG_IMPL_MASK) | events;
        end else begin
            flags <= flags | events;
        end
    end

    // ****************************************
    // Software control registers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            peripheral_event_enables_1 <= ENABLES_RST;
            control <= CONTROL_RST;
            irqMask <= IRQ_MASK_RST;
        end else if (wrLane0) begin
            if (hit(wb_adr_i, OFS_ENABLES)) begin
                peripheral_event_enables_1 <= wb_dat_i[7:0] & FLAG_IMPL_MASK;
            end
            if (hit(wb_adr_i, OFS_CONTROL)) begin
                control <= wb_dat_i[7:0] & CTL_IMPL_MASK;
            end
            if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
                irqMask <= wb_dat_i[7:0] & FLAG_IMPL_MASK;
            end
        end
    end

    // ****************************************
    // Sticky event status, cleared by read
    // ****************************************
    // Only bits that were returned are cleared
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqStatus <= IRQ_STATUS_RST;
        end else if (commit && !wb_we_i && hit(wb_adr_i, OFS_IRQ_STATUS)) begin
            irqStatus <= (irqStatus & ~readSnap) | events;
        end else begin
            irqStatus <= irqStatus | events;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign pending = flags & peripheral_event_enables_1 & FLAG_IMPL_MASK;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            peripheral_event_flags_1 <= FLAGS_RST;
            peripheralIrq <= 1'b0;
            cpuIrq <= 1'b0;
            irq <= 1'b0;
        end else begin
            peripheral_event_flags_1 <= flags & FLAG_IMPL_MASK;
            peripheralIrq <= (|pending) & control[CTL_GROUP_EN];
            cpuIrq <= (|pending) & control[CTL_GROUP_EN]
                & control[CTL_GLOBAL_EN];
            irq <= |(irqStatus & irqMask);
        end
    end

endmodule // peripheral_interrupt_flags
`default_nettype wire

// *** periph_flags_checker.sv ***
// Port assertions for the peripheral flag block, bound to its top.
// Assumes a classic Wishbone master and one-cycle event pulses.
`timescale 1ns/10ps
`default_nettype none
module periph_flags_checker (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [periph_flags_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [periph_flags_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [periph_flags_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic adcDone,
    input wire logic serialXferDone,
    input wire logic timer1Tick,
    input wire logic [15:0] timer1_count,
    input wire logic [7:0] peripheral_event_flags_1,
    input wire logic peripheralIrq,
    input wire logic cpuIrq,
    input wire logic irq
);
    import periph_flags_pkg::*;
    logic wr;
    logic [7:0] flg;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ****
    // Checks
    // ****
    assign flg = peripheral_event_flags_1;
    assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == OFS_FLAGS;
    a_adc_sets: assert property (adcDone |-> ##2
        (flg[BIT_ADC] || $past(wr))) else $error("adc flag missing");
    a_serial_sets: assert property (serialXferDone |-> ##2
        (flg[BIT_SERIAL] || $past(wr))) else $error("serial flag missing");
    a_overflow_sets: assert property (
        timer1Tick && timer1_count == TIMER1_COUNT_MAX |-> ##2
        (flg[BIT_TIMER1_COUNT] || $past(wr))) else $error("overflow flag missing");
    a_unimpl_zero: assert property ((flg & ~FLAG_IMPL_MASK) == 8'h00)
        else $error("unimplemented bit set");
    a_flag_sticky: assert property ((($past(flg) & ~flg) != 8'h00)
        |-> ($past(wr, 2) || $past(srst))) else $error("flag lost");
    a_write_store: assert property (wr |-> ##2
        ((flg & $past(wb_dat_i[7:0], 2) & FLAG_IMPL_MASK) ==
        ($past(wb_dat_i[7:0], 2) & FLAG_IMPL_MASK)))
        else $error("write not stored");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_cpu_gated: assert property (cpuIrq |-> peripheralIrq)
        else $error("cpu request without group");
    a_req_flagged: assert property (peripheralIrq |->
        (flg & FLAG_IMPL_MASK) != 8'h00) else $error("request without flag");
    cover property (adcDone);
    cover property (cpuIrq);
    cover property (irq);
endmodule // periph_flags_checker
bind peripheral_interrupt_flags periph_flags_checker checker_u (
    .ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .adcDone, .serialXferDone, .timer1Tick,
    .timer1_count, .peripheral_event_flags_1, .peripheralIrq, .cpuIrq, .irq
);
`default_nettype wire

// *** periph_model.sv ***
// Peripheral side model: one event per command code 0 to 11.
// Assumes commands change just after a rising ref_clk edge; 15 is idle.
`timescale 1ns/10ps
`default_nettype none
module periph_model (
    input wire logic ref_clk,
    input wire logic [3:0] cmd,
    output var logic [9:0] pulse = 10'h000,
    output var logic [15:0] t1 = 16'h0000,
    output var logic [7:0] t2 = 8'h00
);
    // ****
    // Event pulses and counter values
    // ****
    always @(posedge ref_clk) begin
        pulse <= 10'h000;
        if (cmd < 4'hA) begin
            pulse[cmd] <= 1'b1;
        end
        t1 <= cmd == 4'h9 ? 16'hFFFF : cmd == 4'hA ? 16'h1234 : 16'h0000;
        t2 <= cmd == 4'hB ? 8'h40 : 8'h00;
    end
endmodule // periph_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the peripheral flag block.
// Assumes the partner model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import periph_flags_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = 8'h00;
    logic [SEL_W-1:0] wb_sel_i = 4'h0;
    logic [DAT_W-1:0] wb_dat_i = 32'h0;
    logic [DAT_W-1:0] wb_dat_o;
    logic wb_ack_o, peripheralIrq, cpuIrq, irq;
    logic [7:0] peripheral_event_flags_1, t2;
    logic [3:0] cmd = 4'hF;
    logic idle = 1'b1;
    logic [9:0] p;
    logic [15:0] t1;
    logic [7:0] ctl [4] = '{8'h00, 8'h14, 8'h18, 8'h1C};
    int errors = 0;
    int n_checks = 0;
    always #4 ref_clk = ~ref_clk;
    periph_model model_u (.ref_clk, .cmd, .pulse(p), .t1, .t2);
    peripheral_interrupt_flags dut_u (
        .ref_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .adcDone(p[0]),
        .serialXferDone(p[1]), .serialStartDone(p[2]), .serialStopDone(p[3]),
        .serialRestartDone(p[4]), .serialAckDone(p[5]), .serialIdle(idle),
        .busStartSeen(p[6]), .busStopSeen(p[7]), .ccpCapture(p[8]),
        .ccpCompareValue(16'h1234), .timer1Tick(p[9]), .timer1_count(t1),
        .timer2Count(t2), .timer2_period_value(8'h40),
        .peripheral_event_flags_1, .peripheralIrq, .cpuIrq, .irq
    );
    // ****
    // Tasks
    // ****
    task automatic results();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] q);
        int n;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            results();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, 4'h1, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, 4'hF, q);
        chk(q, {24'h0, e});
    endtask
    task automatic pin(ref logic s, input logic e);
        repeat (2) @(posedge ref_clk);
        chk(32'(s), 32'(e));
    endtask
    task automatic ev(input logic [3:0] c);
        cmd <= c;
        @(posedge ref_clk);
        cmd <= 4'hF;
        repeat (4) @(posedge ref_clk);
    endtask
    function automatic logic [7:0] expv(input int c, input logic [7:0] k);
        case (c)
            0: return 8'h40;
            1: return 8'h08;
            8: return k[3:2] == 2'd0 ? 8'h04 : 8'h00;
            9: return 8'h01;
            10: return k[3:2] == 2'd1 ? 8'h04 : 8'h00;
            11: return 8'h02;
            default: return k[4] ? 8'h08 : 8'h00;
        endcase
    endfunction
    // ****
    // Sequence
    // ****
    initial begin
        logic [31:0] q;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_FLAGS, 8'h00);
        foreach (ctl[j]) begin
            wr(OFS_CONTROL, ctl[j]);
            for (int c = 0; c < 12; c++) begin
                ev(c[3:0]);
                rd(OFS_FLAGS, expv(c, ctl[j]));
                wr(OFS_FLAGS, 8'h00);
                rd(OFS_FLAGS, 8'h00);
            end
            $display("event test with control %h done", ctl[j]);
        end
        idle <= 1'b0;
        wr(OFS_CONTROL, 8'h10);
        ev(4'h6);
        ev(4'h7);
        rd(OFS_FLAGS, 8'h00);
        idle <= 1'b1;
        $display("idle gating test done");
        wr(OFS_FLAGS, 8'hFF);
        rd(OFS_FLAGS, 8'h4F);
        bus(OFS_FLAGS, 1'b1, 8'h00, 4'hE, q);
        rd(OFS_FLAGS, 8'h4F);
        chk(32'(peripheral_event_flags_1), 32'h4F);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        $display("register access test done");
        wr(OFS_ENABLES, 8'h40);
        wr(OFS_CONTROL, 8'h01);
        pin(peripheralIrq, 1'b1);
        pin(cpuIrq, 1'b0);
        wr(OFS_CONTROL, 8'h03);
        pin(cpuIrq, 1'b1);
        wr(OFS_ENABLES, 8'h00);
        pin(peripheralIrq, 1'b0);
        wr(OFS_FLAGS, 8'h00);
        $display("request gating test done");
        rd(OFS_IRQ_STATUS, 8'h4F);
        rd(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_IRQ_MASK, 8'h01);
        rd(OFS_IRQ_MASK, 8'h01);
        ev(4'h9);
        pin(irq, 1'b1);
        ev(4'h0);
        rd(OFS_IRQ_STATUS, 8'h41);
        pin(irq, 1'b0);
        $display("interrupt test done");
        results();
    end
endmodule // testbench
`default_nettype wire
